// file: src/ntlcap_err_flags.sv
`timescale 1ns/1ns
// ============================================================
// Sticky error-detected flags with write-one-to-clear
// ============================================================
module ntlcap_err_flags
  import ntlcap_pkg::*;
#(
  parameter int N = NUM_ERR  // Number of flags
) (
  input  wire logic         clk_i,    // Core clock
  input  wire logic         rst_n_i,  // Async reset, active low
  input  wire logic         ce_i,     // Clock enable
  input  wire logic [N-1:0] det_i,    // Detection pulses
  input  wire logic [N-1:0] clr_i,    // Write-one clear strobes
  output logic      [N-1:0] flag_o    // Latched flags
);
  initial begin
    if (N < 1) $error("N must be at least 1");
  end

  logic [N-1:0] next_flag;  // Flag values for the next edge

  // Set wins over a clear in the same cycle so no event is lost
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_flag
      assign next_flag[g] = det_i[g] | (flag_o[g] & ~clr_i[g]);
    end
  endgenerate

  // One register for all flags keeps a single driver on the vector
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= '0;
    end else if (ce_i) begin
      flag_o <= next_flag;
    end
  end
endmodule

// file: src/ntlcap_pkg.sv
package ntlcap_pkg;
  // ==========================================================
  // Register offsets (byte addresses of 32-bit words)
  // ==========================================================
  localparam logic [7:0] OFS_CAP_HDR   = 8'h68;
  localparam logic [7:0] OFS_DEV_CAP   = 8'h6C;
  localparam logic [7:0] OFS_DEV_STCTL = 8'h70;
  localparam logic [7:0] OFS_LNK_CAP   = 8'h74;
  localparam logic [7:0] OFS_LNK_STCTL = 8'h78;

  // ==========================================================
  // Field values and reset values
  // ==========================================================
  localparam logic [2:0] PAYLOAD_CAP_RST   = 3'h4;  // 2048 bytes
  localparam logic [2:0] PAYLOAD_MAX_CODE  = 3'h4;
  localparam logic [2:0] PAYLOAD_CTL_RST   = 3'h0;  // 128 bytes
  localparam logic       EXT_TAG_CAP       = 1'h0;
  localparam logic [2:0] ACC_LAT_NOLIMIT   = 3'h7;
  localparam logic       ROLE_ERR_RPT      = 1'h1;
  localparam logic [7:0] SLOT_PWR_VAL_RST  = 8'h00;
  localparam logic [1:0] SLOT_PWR_SCL_RST  = 2'h0;
  localparam logic [4:0] INT_MSG_NUM       = 5'h00;
  localparam logic [3:0] SPEEDS_GEN2       = 4'h2;
  localparam logic [3:0] SPEEDS_GEN1       = 4'h1;
  localparam logic [1:0] ASPM_SUPPORT      = 2'h1;  // L0s only
  localparam logic [2:0] L0S_EXIT_GEN2     = 3'h4;
  localparam logic [2:0] L0S_EXIT_GEN1     = 3'h5;
  localparam logic [2:0] L1_EXIT_GEN2      = 3'h1;
  localparam logic [2:0] L1_EXIT_GEN1      = 3'h2;
  localparam logic [1:0] ASPM_CTL_RST      = 2'h0;
  localparam logic [5:0] WIDTH_X1          = 6'h01;
  localparam logic [5:0] WIDTH_X2          = 6'h02;
  localparam logic [5:0] WIDTH_X4          = 6'h04;
  localparam logic [5:0] WIDTH_X8          = 6'h08;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int ERR_EN_LSB    = 0;   // Reporting enables 3:0
  localparam int PAYLOAD_LSB   = 5;   // Payload control 7:5
  localparam int ERR_DET_LSB   = 16;  // Detected flags 19:16
  localparam int SLOT_VAL_LSB  = 18;
  localparam int SLOT_SCL_LSB  = 26;
  localparam int INT_MSG_LSB   = 25;
  localparam int NUM_ERR       = 4;
endpackage

// file: src/ntlcap_regs.sv
`timescale 1ns/1ns
// ============================================================
// PCI Express capability registers, link side of the bridge port
// ============================================================
// Overview of operation
// - Payload capability hardware-initialised to 2048 bytes
// - Extended tag capability reads zero
// - Acceptable L0s and L1 latency read unlimited
// - Slot power value and scale default zero
// - Bits 0..2 enable error reports
// - Bit 3 enables unsupported request reports
// - Payload control read-write, resets to 128
// - Detected error flags sticky, write-one clears
// - Transactions pending always reads zero
// - Unsupported device control bits read zero
// - Supported speeds follow the speed strap
// - Maximum width from straps or preload
// - ASPM support reads L0s only
// - L0s exit latency follows link speed
// - L1 exit latency follows link speed
// - ASPM control read-write, resets disabled
// - Completion boundary bit reads zero
// - Link disable bit reads zero
// - Interrupt message number reads zero
module ntlcap_regs
  import ntlcap_pkg::*;
#(
  parameter int AW = 8  // Config address width
) (
  input  wire logic          clk_i,          // Core clock, 250 MHz
  input  wire logic          rst_n_i,        // Async reset, active low
  input  wire logic          ce_i,           // Clock enable
  input  wire logic          cfg_wr_i,       // Config write strobe
  input  wire logic          cfg_rd_i,       // Config read strobe
  input  wire logic [AW-1:0] cfg_addr_i,     // Config byte address
  input  wire logic [31:0]   cfg_wdata_i,    // Config write data
  input  wire logic [3:0]    cfg_be_i,       // Config byte enables
  output logic      [31:0]   cfg_rdata_o,    // Config read data
  output logic               cfg_rvalid_o,   // Read data valid
  input  wire logic          speed_select_strap_i, // High: 5.0 GT/s
  input  wire logic [1:0]    station_port_config_straps_i, // Width
  input  wire logic [1:0]    nontransparent_port_select_straps_i,
  input  wire logic          pre_valid_i,    // Preload strobe
  input  wire logic [2:0]    pre_payload_i,  // Preload payload cap
  input  wire logic [7:0]    pre_slot_val_i, // Preload slot value
  input  wire logic [1:0]    pre_slot_scl_i, // Preload slot scale
  input  wire logic          pre_width_v_i,  // Preload width valid
  input  wire logic [5:0]    pre_width_i,    // Preload port width
  input  wire logic          link_gen2_i,    // Link at 5.0 GT/s
  input  wire logic [3:0]    err_det_i,      // Cor,NF,Fatal,UR pulses
  output logic      [3:0]    err_rpt_en_o,   // Reporting enables
  output logic      [2:0]    max_payload_o,  // Payload control
  output logic      [1:0]    aspm_ctl_o      // ASPM control
);
  initial begin
    if (AW < 8) $error("AW must be at least 8");
  end

  // ==========================================================
  // Decode
  // ==========================================================
  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0] ofs);
    logic [AW-1:0] ofs_w;  // Offset widened to the address width
    ofs_w = AW'(ofs);
    hit   = (a[AW-1:2] == ofs_w[AW-1:2]);
  endfunction

  wire wr_cap  = cfg_wr_i & hit(cfg_addr_i, OFS_DEV_CAP);
  wire wr_dsc  = cfg_wr_i & hit(cfg_addr_i, OFS_DEV_STCTL);
  wire wr_lsc  = cfg_wr_i & hit(cfg_addr_i, OFS_LNK_STCTL);

  // ==========================================================
  // Straps, captured once after reset
  // ==========================================================
  logic [4:0] strap_q;     // Speed, port config, port select
  logic       strap_done;  // Capture taken
  ntlcap_strap_cap #(.W(5)) u_straps (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .raw_i   ({speed_select_strap_i, station_port_config_straps_i,
               nontransparent_port_select_straps_i}),
    .cap_o   (strap_q),
    .done_o  (strap_done)
  );

  // Strap code 0..3 selects x1, x2, x4, x8
  logic [5:0] strap_width;
  assign strap_width = 6'(6'h01 << strap_q[3:2]);

  // ==========================================================
  // Hardware-initialised fields, writable only by preload
  // ==========================================================
  logic [2:0] payload_cap;  // Supported payload code
  logic [7:0] slot_val;     // Captured slot power value
  logic [1:0] slot_scl;     // Captured slot power scale
  logic [5:0] max_width;    // Maximum link width
  logic       width_pre;    // Width came from preload

  // Preload only accepts the documented payload encodings
  wire pre_pl_ok = (pre_payload_i <= PAYLOAD_MAX_CODE);

  // Host writes to the capability word are ignored (read-only)
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      payload_cap <= PAYLOAD_CAP_RST;
      slot_val    <= SLOT_PWR_VAL_RST;
      slot_scl    <= SLOT_PWR_SCL_RST;
    end else if (ce_i && pre_valid_i) begin
      if (pre_pl_ok) begin
        payload_cap <= pre_payload_i;
      end
      slot_val <= pre_slot_val_i;
      slot_scl <= pre_slot_scl_i;
    end
  end

  // Width from straps unless a preload overrides it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      width_pre <= 1'b0;
      max_width <= WIDTH_X1;
    end else if (ce_i && pre_width_v_i) begin
      width_pre <= 1'b1;
      max_width <= pre_width_i;
    end
  end

  wire [5:0] width_eff = width_pre ? max_width : strap_width;

  // ==========================================================
  // Control registers
  // ==========================================================
  logic [3:0] err_en;    // Error reporting enables
  logic [2:0] pl_ctl;    // Payload control
  logic [1:0] aspm_ctl;  // ASPM control

  // Payload write accepted only for legal codes; the host is
  // expected not to exceed capability, and the hardware does not
  // clamp to it since traffic must already be halted
  wire pl_wr_ok = (cfg_wdata_i[7:5] <= PAYLOAD_MAX_CODE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_en <= 4'h0;
    end else if (ce_i && wr_dsc && cfg_be_i[0]) begin
      err_en <= cfg_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pl_ctl <= PAYLOAD_CTL_RST;
    end else if (ce_i && wr_dsc && cfg_be_i[0] && pl_wr_ok) begin
      pl_ctl <= cfg_wdata_i[7:5];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aspm_ctl <= ASPM_CTL_RST;
    end else if (ce_i && wr_lsc && cfg_be_i[0]) begin
      aspm_ctl <= cfg_wdata_i[1:0];
    end
  end

  // ==========================================================
  // Detected error flags
  // ==========================================================
  logic [3:0] err_flag;  // Cor, NF, Fatal, UR detected
  wire  [3:0] err_clr = (wr_dsc && cfg_be_i[2]) ? cfg_wdata_i[19:16]
                                                 : 4'h0;
  ntlcap_err_flags #(.N(NUM_ERR)) u_flags (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .det_i   (err_det_i),
    .clr_i   (err_clr),
    .flag_o  (err_flag)
  );

  // ==========================================================
  // Read word assembly; all unlisted bits are zero
  // ==========================================================
  wire [31:0] rd_hdr = {2'h0, INT_MSG_NUM, 25'h0};

  wire [31:0] rd_dcap = {4'h0, slot_scl, slot_val, 2'h0,
                         ROLE_ERR_RPT, 3'h0,
                         ACC_LAT_NOLIMIT, ACC_LAT_NOLIMIT,
                         EXT_TAG_CAP, 2'h0, payload_cap};

  // Bit 21 pending and bits 15:8, 4 reserved stay zero
  wire [31:0] rd_dsc = {12'h000, err_flag, 8'h00,
                        pl_ctl, 1'b0, err_en};

  wire [3:0] speeds  = strap_q[4] ? SPEEDS_GEN2 : SPEEDS_GEN1;
  wire [2:0] l0s_ex  = link_gen2_i ? L0S_EXIT_GEN2
                                   : L0S_EXIT_GEN1;
  wire [2:0] l1_ex   = link_gen2_i ? L1_EXIT_GEN2
                                   : L1_EXIT_GEN1;
  wire [7:0] port_no = {6'h00, strap_q[1:0]};

  wire [31:0] rd_lcap = {port_no, 5'h00, 1'b0, l1_ex, l0s_ex,
                         ASPM_SUPPORT, width_eff, speeds};

  // Bits 3 and 4 read zero; link status lives elsewhere
  wire [31:0] rd_lsc = {27'h0, 1'b0, 1'b0, 1'b0,
                        aspm_ctl};

  logic [31:0] rd_mux;  // Selected read word
  always_comb begin
    rd_mux = 32'h0000_0000;  // Unmapped reads return zero
    if (hit(cfg_addr_i, OFS_CAP_HDR))   rd_mux = rd_hdr;
    if (hit(cfg_addr_i, OFS_DEV_CAP))   rd_mux = rd_dcap;
    if (hit(cfg_addr_i, OFS_DEV_STCTL)) rd_mux = rd_dsc;
    if (hit(cfg_addr_i, OFS_LNK_CAP))   rd_mux = rd_lcap;
    if (hit(cfg_addr_i, OFS_LNK_STCTL)) rd_mux = rd_lsc;
  end

  // Read data registered: answer one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o  <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= rd_mux;
      end
    end
  end

  assign err_rpt_en_o  = err_en;
  assign max_payload_o = pl_ctl;
  assign aspm_ctl_o    = aspm_ctl;

  // ==========================================================
  // Checks
  // ==========================================================
  a_flag_set_holds: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ce_i && err_det_i[0] |=> err_flag[0])
    else $error("correctable flag not set after detection");

  a_flag_w1c: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ce_i && err_clr[1] && !err_det_i[1] |=> !err_flag[1])
    else $error("non-fatal flag not cleared by write one");

  a_payload_rst: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    $rose(strap_done) |-> pl_ctl == PAYLOAD_CTL_RST ||
                          $past(wr_dsc))
    else $error("payload control not at reset value");

  a_payload_legal: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    pl_ctl <= PAYLOAD_MAX_CODE)
    else $error("payload control holds illegal code");

  a_cap_ro: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ce_i && wr_cap && !pre_valid_i |=> $stable(payload_cap))
    else $error("host write changed payload capability");

  a_speed_map: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cfg_rd_i && ce_i && hit(cfg_addr_i, OFS_LNK_CAP) |=>
      cfg_rdata_o[3:0] == (strap_q[4] ? 4'h2 : 4'h1))
    else $error("supported speeds do not match strap");

  a_exit_lat: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cfg_rd_i && ce_i && hit(cfg_addr_i, OFS_LNK_CAP) |=>
      cfg_rdata_o[14:12] == ($past(link_gen2_i) ? 3'h4 : 3'h5) &&
      cfg_rdata_o[11:10] == 2'h1)
    else $error("link capability latency or ASPM wrong");

  a_dsc_rsvd: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cfg_rvalid_o && $past(hit(cfg_addr_i, OFS_DEV_STCTL)) |->
      cfg_rdata_o[15:8] == 8'h00 && cfg_rdata_o[31:20] == 12'h000)
    else $error("reserved device control bits not zero");

  a_lsc_rsvd: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cfg_rvalid_o && $past(hit(cfg_addr_i, OFS_LNK_STCTL)) |->
      cfg_rdata_o[4:2] == 3'h0)
    else $error("link control reserved bits not zero");

  a_flag_set_wins: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ce_i && err_det_i[3] && err_clr[3] |=> err_flag[3])
    else $error("clear beat a detection in the same cycle");

  a_ce_freeze: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    !ce_i |=> $stable(aspm_ctl) && $stable(pl_ctl) &&
              $stable(err_flag) && $stable(cfg_rvalid_o))
    else $error("state changed while clock enable low");

  a_unmapped_zero: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ce_i && cfg_rd_i && hit(cfg_addr_i, 8'h7C) |=> cfg_rdata_o == '0)
    else $error("unmapped word did not read zero");
endmodule

// file: src/ntlcap_strap_cap.sv
`timescale 1ns/1ns
// ============================================================
// Capture of strap levels after reset release
// ============================================================
module ntlcap_strap_cap
  import ntlcap_pkg::*;
#(
  parameter int W = 8  // Width of captured word
) (
  input  wire logic         clk_i,    // Core clock
  input  wire logic         rst_n_i,  // Async reset, active low
  input  wire logic         ce_i,     // Clock enable
  input  wire logic [W-1:0] raw_i,    // Strap levels
  output logic      [W-1:0] cap_o,    // Captured straps
  output logic              done_o    // Capture taken
);
  initial begin
    if (W < 1) $error("W must be at least 1");
  end

  // Straps sampled on the first enabled edge after release; async
  // reset may only load constants, so the capture is clocked
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_o  <= '0;
      done_o <= 1'b0;
    end else if (ce_i && !done_o) begin
      cap_o  <= raw_i;
      done_o <= 1'b1;
    end
  end
endmodule

// file: testbench/ntlcap_host_model.sv
`timescale 1ns/1ns
// ============================================================
// Host side model: issues one configuration access at a time
// ============================================================
module ntlcap_host_model (
  input  wire logic        clk_i,        // Core clock
  output logic             cfg_wr_o,     // Write strobe
  output logic             cfg_rd_o,     // Read strobe
  output logic [7:0]       cfg_addr_o,   // Byte address
  output logic [31:0]      cfg_wdata_o,  // Write data
  output logic [3:0]       cfg_be_o,     // Byte enables
  input  wire logic [31:0] cfg_rdata_i,  // Read data
  input  wire logic        cfg_rvalid_i  // Read data valid
);
  // Idle lines start at a known level
  initial begin
    cfg_wr_o    = 1'b0;
    cfg_rd_o    = 1'b0;
    cfg_addr_o  = 8'hFF;
    cfg_wdata_o = 32'hFFFF_FFFF;
    cfg_be_o    = 4'h0;
  end

  // One write; lines show inverted values once released, so a
  // design that samples late cannot pass by luck
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    @(posedge clk_i);
    cfg_wr_o    <= 1'b1;
    cfg_addr_o  <= a;
    cfg_wdata_o <= d;
    cfg_be_o    <= be;
    @(posedge clk_i);
    cfg_wr_o    <= 1'b0;
    cfg_addr_o  <= ~a;
    cfg_wdata_o <= ~d;
    cfg_be_o    <= ~be;
  endtask

  // One read; waits a bounded number of cycles for the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output bit ok);
    ok = 1'b0;
    d  = 32'h0;
    @(posedge clk_i);
    cfg_rd_o   <= 1'b1;
    cfg_addr_o <= a;
    @(posedge clk_i);
    cfg_rd_o   <= 1'b0;
    cfg_addr_o <= ~a;
    // Answer taken at the edge that samples valid high
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      if (cfg_rvalid_i === 1'b1) begin
        d  = cfg_rdata_i;
        ok = 1'b1;
        break;
      end
    end
  endtask
endmodule

// file: testbench/tb_ntlcap_regs.sv
`timescale 1ns/1ns
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED %0t: got %h expected %h", $time, g, e); \
  end \
end
module tb_ntlcap_regs;
  import ntlcap_pkg::*;
  logic        clk, rst_n, ce;              // Clock, reset, enable
  logic        cfg_wr, cfg_rd, cfg_rvalid;  // Access strobes
  logic [7:0]  cfg_addr;                    // Access address
  logic [31:0] cfg_wdata, cfg_rdata;        // Access data
  logic [3:0]  cfg_be, err_det, err_en;     // Enables and events
  logic        spd_strap, pre_valid, pre_wv, gen2; // Straps, preload
  logic [1:0]  wid_strap, port_strap, pre_scl, aspm;
  logic [2:0]  pre_pay, payload;            // Preload and control
  logic [7:0]  pre_val;                     // Preload slot value
  logic [5:0]  pre_wid;                     // Preload width
  int          n_errors, checked;           // Counters
  // Expected register state kept by the bench
  logic [2:0]  e_cap, e_pay;
  logic [7:0]  e_val;
  logic [1:0]  e_scl, e_aspm, e_port;
  logic [5:0]  e_wid;
  logic [3:0]  e_en, e_flags, e_spd, m, k, bb;

  always #2 clk = ~clk;  // 250 MHz

  ntlcap_host_model u_ntlcap_host_model (.clk_i(clk), .cfg_wr_o(cfg_wr),
    .cfg_rd_o(cfg_rd), .cfg_addr_o(cfg_addr), .cfg_wdata_o(cfg_wdata),
    .cfg_be_o(cfg_be), .cfg_rdata_i(cfg_rdata), .cfg_rvalid_i(cfg_rvalid));

  ntlcap_regs u_ntlcap_regs (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr),
    .cfg_wdata_i(cfg_wdata), .cfg_be_i(cfg_be), .cfg_rdata_o(cfg_rdata),
    .cfg_rvalid_o(cfg_rvalid), .speed_select_strap_i(spd_strap),
    .station_port_config_straps_i(wid_strap),
    .nontransparent_port_select_straps_i(port_strap),
    .pre_valid_i(pre_valid), .pre_payload_i(pre_pay),
    .pre_slot_val_i(pre_val), .pre_slot_scl_i(pre_scl),
    .pre_width_v_i(pre_wv), .pre_width_i(pre_wid), .link_gen2_i(gen2),
    .err_det_i(err_det), .err_rpt_en_o(err_en), .max_payload_o(payload),
    .aspm_ctl_o(aspm));

  // ==========================================================
  // Expected register words
  // ==========================================================
  function automatic logic [31:0] exp_reg(input logic [7:0] a);
    case (a)
      OFS_DEV_CAP:   return {4'h0, e_scl, e_val, 2'h0, 1'b1, 3'h0, 3'h7,
                             3'h7, 1'b0, 2'h0, e_cap};
      OFS_DEV_STCTL: return {12'h0, e_flags, 8'h0, e_pay, 1'b0, e_en};
      OFS_LNK_CAP:   return {6'h0, e_port, 6'h0, gen2 ? 3'h1 : 3'h2,
                             gen2 ? 3'h4 : 3'h5, 2'h1, e_wid, e_spd};
      OFS_LNK_STCTL: return {30'h0, e_aspm};
      default:       return 32'h0;
    endcase
  endfunction

  // Verdict; the one place where the run ends
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Read one word and compare it with the expectation
  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] d;
    bit          ok;
    u_ntlcap_host_model.rd(a, d, ok);
    if (!ok) begin
      n_errors++;
      $display("CHECK FAILED %0t: read got no answer", $time);
      finish_test();
    end else begin
      `CHK(d, exp_reg(a))
    end
  endtask

  // Whole map, including an unmapped word
  task automatic chk_all();
    logic [7:0] ofs [6];
    ofs = '{OFS_CAP_HDR, OFS_DEV_CAP, OFS_DEV_STCTL, OFS_LNK_CAP,
            OFS_LNK_STCTL, 8'h7C};
    foreach (ofs[i]) rd_chk(ofs[i]);
    `CHK(err_en, e_en)
    `CHK(payload, e_pay)
    `CHK(aspm, e_aspm)
  endtask

  // One-cycle error detection pulses
  task automatic pulse(input logic [3:0] mask);
    @(posedge clk);
    err_det <= mask;
    @(posedge clk);
    err_det <= 4'h0;
    e_flags = e_flags | mask;
  endtask

  initial begin
    {clk, rst_n, pre_valid, pre_wv, gen2, spd_strap} = 6'h00;
    {err_det, pre_pay, pre_val, pre_scl, pre_wid} = 23'h0;
    {wid_strap, port_strap} = 4'h0;
    ce       = 1'b1;
    n_errors = 0;
    checked  = 0;
    void'($urandom(32'h1fc2));
    // ========================================================
    // Reset values under both speed straps
    // ========================================================
    for (int r = 0; r < 2; r++) begin
      spd_strap  <= r[0];
      wid_strap  <= 2'($urandom);
      port_strap <= 2'($urandom);
      gen2       <= 1'($urandom);
      rst_n      <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      {e_cap, e_val, e_scl, e_en, e_flags} = {3'h4, 18'h0};
      {e_pay, e_aspm, e_port} = {5'h0, port_strap};
      e_wid = 6'h01 << wid_strap;
      e_spd = spd_strap ? 4'h2 : 4'h1;
      chk_all();
      $display("test reset %0d done", r);
    end
    // ========================================================
    // All ones everywhere: only writable fields take it
    // ========================================================
    for (int a = 8'h68; a <= 8'h7C; a += 4)
      u_ntlcap_host_model.wr(8'(a), 32'hFFFF_FFFF, 4'hF);
    {e_en, e_aspm} = {4'hF, 2'h3};
    chk_all();
    $display("test write ones done");
    // Every payload code, then one above the capability
    for (int c = 0; c <= 5; c++) begin
      u_ntlcap_host_model.wr(OFS_DEV_STCTL, {24'h0, 3'(c), 5'h1F}, 4'h1);
      if (c <= 4) e_pay = 3'(c);
      chk_all();
    end
    // Every power-management control code
    for (int c = 0; c < 4; c++) begin
      u_ntlcap_host_model.wr(OFS_LNK_STCTL, {30'h3FFF_FFFF, 2'(c)}, 4'hF);
      e_aspm = 2'(c);
      rd_chk(OFS_LNK_STCTL);
      `CHK(aspm, e_aspm)
    end
    $display("test control codes done");
    // ========================================================
    // Sticky flags whatever the enables; write-one clears
    // ========================================================
    for (int i = 0; i < 12; i++) begin
      e_en = 4'($urandom);
      u_ntlcap_host_model.wr(OFS_DEV_STCTL, {24'h0, e_pay, 1'b0, e_en},
                             4'h1);
      m = 4'($urandom);
      pulse(m);
      rd_chk(OFS_DEV_STCTL);
      k  = 4'($urandom);
      bb = 4'($urandom);
      u_ntlcap_host_model.wr(OFS_DEV_STCTL,
                             {12'h0, k, 8'h0, e_pay, 1'b0, e_en}, bb);
      if (bb[2]) e_flags = e_flags & ~k;
      rd_chk(OFS_DEV_STCTL);
      `CHK(err_en, e_en)
    end
    $display("test error flags done");
    // Detection and write-one clear in one cycle: detection wins
    fork
      pulse(4'hF);
      u_ntlcap_host_model.wr(OFS_DEV_STCTL,
                             {12'h0, 4'hF, 8'h0, e_pay, 1'b0, e_en}, 4'h4);
    join
    rd_chk(OFS_DEV_STCTL);
    u_ntlcap_host_model.wr(OFS_DEV_STCTL, 32'h000F_0000, 4'h4);
    e_flags = 4'h0;
    rd_chk(OFS_DEV_STCTL);
    // Clock enable low: a write and detections must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    fork
      u_ntlcap_host_model.wr(OFS_LNK_STCTL, ~{30'h0, e_aspm}, 4'hF);
      begin
        @(posedge clk);
        err_det <= 4'hF;
        @(posedge clk);
        err_det <= 4'h0;
      end
    join
    ce <= 1'b1;
    chk_all();
    $display("test corner cases done");
    // ========================================================
    // Preload of capability fields, and link speed changes
    // ========================================================
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      pre_valid <= 1'b1;
      pre_pay   <= (i == 0) ? 3'h6 : 3'($urandom);
      pre_val   <= 8'($urandom);
      pre_scl   <= 2'($urandom);
      pre_wv    <= 1'($urandom);
      pre_wid   <= 6'h01 << 2'($urandom);
      gen2      <= ~gen2;
      @(posedge clk);
      pre_valid <= 1'b0;
      pre_wv    <= 1'b0;
      if (pre_pay <= 3'h4) e_cap = pre_pay;
      {e_val, e_scl} = {pre_val, pre_scl};
      if (pre_wv) e_wid = pre_wid;
      chk_all();
    end
    $display("test preload done");
    finish_test();
  end
endmodule
